// ---- core/rgi_consts.svh ----
`ifndef RGI_CONSTS_SVH
`define RGI_CONSTS_SVH

// bus addressing
`define RGI_CHIP_ADDR   7'h36
`define RGI_BYTE_BITS   4'h8

// register indices
`define RGI_IDX_CTRL    8'h00
`define RGI_IDX_BUCK1   8'h01
`define RGI_IDX_BUCK2   8'h02

// reset values
`define RGI_CTRL_RST    8'h00
`define RGI_BUCK1_RST   8'h05
`define RGI_BUCK2_RST   8'h01

// field positions
`define RGI_BIT_MSTEP   0
`define RGI_BIT_MODE    5
`define RGI_BIT_PORDIS  6
`define RGI_CODE_MSB    4

// timing
`define RGI_CLK_MHZ     250
`define RGI_SPIKE_NS    50
`define RGI_FILT_CYC    ((`RGI_SPIKE_NS * `RGI_CLK_MHZ + 999) / 1000)
`define RGI_STEP_US     32
`define RGI_STEP_CYC    (`RGI_STEP_US * `RGI_CLK_MHZ)

`endif

// ---- core/rgi_filter.sv ----
`timescale 1ns/10ps
`include "rgi_consts.svh"

module rgi_filter #(
   parameter logic RST_LVL = 1'b1
) (
   input  wire logic clock_i,
   input  wire logic reset_i,
   input  wire logic pin_i,
   output logic      level_o
);

   logic       sync1;
   logic       sync2;
   logic [3:0] cnt;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         sync1 <= RST_LVL;
         sync2 <= RST_LVL;
      end else begin
         sync1 <= pin_i;
         sync2 <= sync1;
      end
   end

   // a new level is taken only after it held for the whole spike window
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         cnt     <= 4'h0;
         level_o <= RST_LVL;
      end else if (sync2 == level_o) begin
         cnt <= 4'h0;
      end else if (cnt == 4'(`RGI_FILT_CYC - 1)) begin // [RULE18]
         cnt     <= 4'h0;
         level_o <= sync2;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end

   AST_SPIKE: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE18]
      $changed(level_o) |-> $past(sync2, 1) == level_o && $past(sync2, 13) == level_o)
      else $error("filtered level changed on a short pulse");

endmodule // rgi_filter

// ---- core/rgi_pkg.sv ----
package rgi_pkg;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_ADDR   = 6'h02,
      ST_INDEX  = 6'h04,
      ST_WDATA  = 6'h08,
      ST_RDATA  = 6'h10,
      ST_IGNORE = 6'h20
   } rgi_state_t;

   typedef struct packed {
      logic [7:0] idx;
      logic [7:0] data;
   } rgi_wr_t;

endpackage

// ---- core/rgi_port.sv ----
`timescale 1ns/10ps
`include "rgi_consts.svh"

// Summary of operation
// [RULE1] scl and sda are open-drain, pulled low only
// [RULE2] master clocks at most 400 kHz
// [RULE3] sda changes only while scl is low
// [RULE4] sda fall with scl high starts session
// [RULE5] sda rise with scl high stops session
// [RULE6] only the master makes start and stop
// [RULE7] bus busy from start until stop
// [RULE8] repeated start acts as first start
// [RULE9] bytes are eight bits, msb first
// [RULE10] no limit on bytes per transfer
// [RULE11] receiver pulls sda low on ninth clock
// [RULE12] master supplies the acknowledge clock
// [RULE13] addressed device acknowledges every received byte
// [RULE14] first byte: seven-bit address plus direction
// [RULE15] respond only to chip address 36h
// [RULE16] write: index byte, then data byte
// [RULE17] read: write index, repeated start, read
// [RULE18] spikes up to 50 ns are ignored
// [RULE19] mode bit forces fixed-frequency pwm
// [RULE20] soft start on enable rise after supply good
// [RULE21] three registers at indices 00, 01, 02
// [RULE22] five-bit output code per converter
// [RULE23] micro-stepping moves one code per 32 us
// [RULE24] unmatched address: stay released until start/stop
// [RULE25] writes to undefined index change nothing
module rgi_port #(
   parameter int STEP_CYC = `RGI_STEP_CYC
) (
   input  wire logic       clock_i,
   input  wire logic       reset_i,
   input  wire logic       scl_i,
   output logic            scl_o,
   output logic            scl_oe_o,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic [1:0] en_i,
   input  wire logic       vin_ok_i,
   input  wire logic       hold_i,
   output logic [7:0]      ctrl_o,
   output logic [7:0]      buck1_o,
   output logic [7:0]      buck2_o,
   output logic [1:0]      pwm_force_o,
   output logic            por_dis_o,
   output logic [4:0]      vcode1_o,
   output logic [4:0]      vcode2_o,
   output logic [1:0]      soft_start_o,
   output logic            busy_o
);

   ////////////////////////////////////////////////////////////////////////////
   // input filters: scl, sda, en[0], en[1], vin_ok
   logic [4:0] pin_raw;
   logic [4:0] pin_lvl;
   logic [4:0] pin_q;

   assign pin_raw = {vin_ok_i, en_i, sda_i, scl_i};

   for (genvar k = 0; k < 5; k++) begin : g_filt
      rgi_filter #(
         .RST_LVL (k < 2 ? 1'b1 : 1'b0)
      ) u_filt (
         .clock_i (clock_i),
         .reset_i (reset_i),
         .pin_i   (pin_raw[k]),
         .level_o (pin_lvl[k])
      );
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         pin_q <= 5'h03;
      end else begin
         pin_q <= pin_lvl;
      end
   end

   logic scl_f;
   logic sda_f;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   assign scl_f     = pin_lvl[0];
   assign sda_f     = pin_lvl[1];
   assign scl_rise  = scl_f & ~pin_q[0];
   assign scl_fall  = ~scl_f & pin_q[0];
   assign start_det = scl_f & pin_q[0] & pin_q[1] & ~sda_f; // [RULE4]
   assign stop_det  = scl_f & pin_q[0] & ~pin_q[1] & sda_f; // [RULE5]

   ////////////////////////////////////////////////////////////////////////////
   // protocol engine
   rgi_pkg::rgi_state_t state;
   rgi_pkg::rgi_wr_t    pend_wd;
   logic [3:0]          bit_cnt;
   logic [7:0]          shreg;
   logic [7:0]          tx;
   logic [7:0]          idx;
   logic                ack_ph;
   logic                ack_own;
   logic                mnack;
   logic                pend;
   logic                sda_oe;
   logic                busy;
   logic [7:0]          ctrl;
   logic [7:0]          buck1;
   logic [7:0]          buck2;

   function automatic logic [7:0] reg_sel(input logic [7:0] i);
      if (i == `RGI_IDX_CTRL) begin
         reg_sel = ctrl;
      end else if (i == `RGI_IDX_BUCK1) begin
         reg_sel = buck1;
      end else if (i == `RGI_IDX_BUCK2) begin
         reg_sel = buck2;
      end else begin
         reg_sel = 8'h00;
      end
   endfunction

   logic       live;
   logic       byte_done;
   logic       ack_end;
   logic       addr_hit;
   logic       buf_in_ready;
   logic [7:0] idx_nx;
   logic [7:0] rd_cur;
   logic [7:0] rd_next;

   assign live      = state != rgi_pkg::ST_IDLE && state != rgi_pkg::ST_IGNORE;
   assign byte_done = scl_fall & ~ack_ph & live & (bit_cnt == `RGI_BYTE_BITS); // [RULE9]
   assign ack_end   = scl_fall & ack_ph;
   assign addr_hit  = shreg[7:1] == `RGI_CHIP_ADDR; // [RULE15]
   assign idx_nx    = idx + 8'h01;
   assign rd_cur    = reg_sel(idx);
   assign rd_next   = reg_sel(idx_nx);

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         bit_cnt <= 4'h0;
         shreg   <= 8'h00;
         mnack   <= 1'b0;
      end else if (start_det || stop_det) begin
         bit_cnt <= 4'h0;
      end else if (byte_done) begin
         bit_cnt <= 4'h0;
      end else if (scl_rise && ack_ph) begin
         mnack <= sda_f;
      end else if (scl_rise && live && bit_cnt != `RGI_BYTE_BITS) begin
         shreg   <= {shreg[6:0], sda_f}; // [RULE3] [RULE9]
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state   <= rgi_pkg::ST_IDLE;
         ack_ph  <= 1'b0;
         ack_own <= 1'b0;
         sda_oe  <= 1'b0;
         busy    <= 1'b0;
         idx     <= 8'h00;
         tx      <= 8'h00;
         pend    <= 1'b0;
         pend_wd <= '0;
      end else begin
         if (pend && buf_in_ready) begin
            pend <= 1'b0;
         end
         if (start_det) begin
            state  <= rgi_pkg::ST_ADDR; // [RULE8]
            ack_ph <= 1'b0;
            sda_oe <= 1'b0;
            busy   <= 1'b1; // [RULE7]
         end else if (stop_det) begin
            state  <= rgi_pkg::ST_IDLE;
            ack_ph <= 1'b0;
            sda_oe <= 1'b0;
            busy   <= 1'b0; // [RULE7]
         end else if (byte_done) begin
            ack_ph  <= 1'b1;
            ack_own <= state != rgi_pkg::ST_RDATA;
            sda_oe  <= state != rgi_pkg::ST_RDATA; // [RULE11] [RULE13]
            case (state)
               rgi_pkg::ST_ADDR: begin
                  if (addr_hit) begin
                     state <= shreg[0] ? rgi_pkg::ST_RDATA : rgi_pkg::ST_INDEX; // [RULE14]
                     tx    <= rd_cur; // [RULE17]
                  end else begin
                     state   <= rgi_pkg::ST_IGNORE; // [RULE24]
                     ack_own <= 1'b0;
                     sda_oe  <= 1'b0;
                  end
               end
               rgi_pkg::ST_INDEX: begin
                  idx   <= shreg; // [RULE16]
                  state <= rgi_pkg::ST_WDATA;
               end
               rgi_pkg::ST_WDATA: begin
                  pend    <= 1'b1; // [RULE10] [RULE16]
                  pend_wd <= '{idx: idx, data: shreg};
                  idx     <= idx_nx;
               end
               default: begin
               end
            endcase
         end else if (ack_end) begin
            ack_ph  <= 1'b0;
            ack_own <= 1'b0;
            if (state != rgi_pkg::ST_RDATA) begin
               sda_oe <= 1'b0;
            end else if (ack_own) begin
               sda_oe <= ~tx[7];
            end else if (mnack) begin
               state  <= rgi_pkg::ST_IGNORE;
               sda_oe <= 1'b0;
            end else begin
               idx    <= idx_nx;
               tx     <= rd_next;
               sda_oe <= ~rd_next[7];
            end
         end else if (scl_fall && state == rgi_pkg::ST_RDATA && !ack_ph) begin
            sda_oe <= ~tx[3'(4'h7 - bit_cnt)]; // [RULE3] [RULE9]
         end
      end
   end

   // open-drain: the lines are only ever pulled low
   assign scl_o    = 1'b0; // [RULE1]
   assign sda_o    = 1'b0; // [RULE1]
   assign sda_oe_o = sda_oe;
   assign scl_oe_o = pend; // holds scl low while a received data byte waits for room in the write buffer
   assign busy_o   = busy;

   ////////////////////////////////////////////////////////////////////////////
   // two-entry write buffer between the bus and the registers
   rgi_pkg::rgi_wr_t fifo_mem [2];
   rgi_pkg::rgi_wr_t drain_wd;
   logic             wp;
   logic             rp;
   logic [1:0]       fcnt;
   logic             push;
   logic             pop;

   assign buf_in_ready = fcnt != 2'h2;
   assign push         = pend & buf_in_ready;
   assign pop          = (fcnt != 2'h0) & ~hold_i;
   assign drain_wd     = fifo_mem[rp];

   always_ff @(posedge clock_i) begin
      if (push) begin
         fifo_mem[wp] <= pend_wd;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         wp   <= 1'b0;
         rp   <= 1'b0;
         fcnt <= 2'h0;
      end else begin
         wp   <= wp ^ push;
         rp   <= rp ^ pop;
         fcnt <= fcnt + {1'b0, push} - {1'b0, pop};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ctrl  <= `RGI_CTRL_RST;
         buck1 <= `RGI_BUCK1_RST;
         buck2 <= `RGI_BUCK2_RST;
      end else if (pop) begin
         if (drain_wd.idx == `RGI_IDX_CTRL) begin // [RULE21]
            ctrl <= drain_wd.data;
         end else if (drain_wd.idx == `RGI_IDX_BUCK1) begin
            buck1 <= drain_wd.data;
         end else if (drain_wd.idx == `RGI_IDX_BUCK2) begin
            buck2 <= drain_wd.data;
         end // [RULE25]
      end
   end

   assign ctrl_o      = ctrl;
   assign buck1_o     = buck1;
   assign buck2_o     = buck2;
   assign pwm_force_o = {buck2[`RGI_BIT_MODE], buck1[`RGI_BIT_MODE]}; // [RULE19]
   assign por_dis_o   = buck2[`RGI_BIT_PORDIS];

   ////////////////////////////////////////////////////////////////////////////
   // micro-stepping and soft start per converter
   logic [15:0]      step_cnt;
   logic             step_tick;
   logic [4:0]       vcode [2];
   logic [4:0]       target [2];
   logic             ss [2];

   assign step_tick = step_cnt == 16'(STEP_CYC - 1);
   assign target[0] = buck1[`RGI_CODE_MSB:0]; // [RULE22]
   assign target[1] = buck2[`RGI_CODE_MSB:0];

   always_ff @(posedge clock_i) begin
      if (reset_i || step_tick) begin
         step_cnt <= 16'h0000;
      end else begin
         step_cnt <= step_cnt + 16'h0001;
      end
   end

   for (genvar c = 0; c < 2; c++) begin : g_chan
      always_ff @(posedge clock_i) begin
         if (reset_i) begin
            vcode[c] <= (c == 0) ? 5'(`RGI_BUCK1_RST) : 5'(`RGI_BUCK2_RST);
         end else if (!ctrl[`RGI_BIT_MSTEP]) begin
            vcode[c] <= target[c];
         end else if (step_tick && vcode[c] < target[c]) begin
            vcode[c] <= vcode[c] + 5'h01; // [RULE23]
         end else if (step_tick && vcode[c] > target[c]) begin
            vcode[c] <= vcode[c] - 5'h01; // [RULE23]
         end
      end

      always_ff @(posedge clock_i) begin
         if (reset_i) begin
            ss[c] <= 1'b0;
         end else begin
            ss[c] <= pin_lvl[2 + c] & ~pin_q[2 + c] & pin_lvl[4]; // [RULE20]
         end
      end
   end

   assign vcode1_o     = vcode[0];
   assign vcode2_o     = vcode[1];
   assign soft_start_o = {ss[1], ss[0]};

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_START: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE4] [RULE8]
      start_det |=> state == rgi_pkg::ST_ADDR && bit_cnt == 4'h0 && busy)
      else $error("start did not restart the address phase");

   AST_STOP: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE5] [RULE7]
      stop_det |=> state == rgi_pkg::ST_IDLE && !busy && !sda_oe)
      else $error("stop did not free the bus");

   AST_SDA_LOW: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE3]
      $changed(sda_oe) && !$past(start_det) && !$past(stop_det) |-> !scl_f)
      else $error("sda drive changed while scl high");

   AST_NOMATCH: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE15] [RULE24]
      byte_done && state == rgi_pkg::ST_ADDR && !addr_hit
      |=> state == rgi_pkg::ST_IGNORE && !sda_oe)
      else $error("foreign address was answered");

   AST_ACK: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE11] [RULE13]
      byte_done && (state == rgi_pkg::ST_INDEX || state == rgi_pkg::ST_WDATA)
      |=> sda_oe && ack_ph)
      else $error("received byte not acknowledged");

   AST_UNMAPPED: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE25]
      pop && drain_wd.idx > `RGI_IDX_BUCK2 |=> $stable(ctrl) && $stable(buck1) && $stable(buck2))
      else $error("undefined index changed a setting");

   AST_PWM: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE19] [RULE16]
      pop && drain_wd.idx == `RGI_IDX_BUCK1
      |=> pwm_force_o[0] == $past(drain_wd.data[`RGI_BIT_MODE]))
      else $error("forced pwm bit not taken");

   AST_SOFT: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE20]
      soft_start_o[0] |-> $past(pin_lvl[4]) && $past(pin_lvl[2]) && !$past(pin_q[2]))
      else $error("soft start without enable rise and good supply");

   AST_MSTEP: assert property (@(posedge clock_i) disable iff (reset_i) // [RULE23]
      ctrl[`RGI_BIT_MSTEP] && $past(ctrl[`RGI_BIT_MSTEP]) && !$past(step_tick)
      |-> $stable(vcode1_o))
      else $error("micro-step moved between ticks");

endmodule // rgi_port

// ---- verif/regulator_i2c_register_port_bench.sv ----
`timescale 1ns/10ps
`include "rgi_consts.svh"

module regulator_i2c_register_port_bench;
   localparam int STEP = 200;
   localparam logic [7:0] WA = {`RGI_CHIP_ADDR, 1'b0};
   localparam logic [7:0] RA = {`RGI_CHIP_ADDR, 1'b1};
   logic       clk;
   logic       rst;
   logic [1:0] en;
   logic       vin_ok;
   logic       hold;
   logic       m_scl;
   logic       m_sda;
   logic       scl_oe;
   logic       sda_oe;
   logic [7:0] ctrl;
   logic [7:0] buck1;
   logic [7:0] buck2;
   logic [1:0] pwm_force;
   logic [1:0] soft_start;
   logic       por_dis;
   logic       busy;
   logic [4:0] vcode1;
   logic [4:0] vcode2;
   int         fails;
   int         n_compared;
   int         ss_cnt [2];
   // open-drain lines with pull-ups
   wire        scl = ~(m_scl | scl_oe);
   wire        sda = ~(m_sda | sda_oe);

   rgi_port #(.STEP_CYC(STEP)) i_dut (
      .clock_i(clk), .reset_i(rst), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
      .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .en_i(en), .vin_ok_i(vin_ok),
      .hold_i(hold), .ctrl_o(ctrl), .buck1_o(buck1), .buck2_o(buck2),
      .pwm_force_o(pwm_force), .por_dis_o(por_dis), .vcode1_o(vcode1),
      .vcode2_o(vcode2), .soft_start_o(soft_start), .busy_o(busy)
   );

   rgi_master i_master (
      .clock_i(clk), .scl_i(scl), .sda_i(sda), .scl_low_o(m_scl), .sda_low_o(m_sda)
   );

   always #2 clk = ~clk;

   always @(posedge clk) begin
      for (int i = 0; i < 2; i++) if (soft_start[i] === 1'b1) ss_cnt[i]++;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic wr(input logic [7:0] idx, d);
      logic a;
      i_master.start();
      i_master.send(WA, a);
      check(a, 1, "write address ack");
      i_master.send(idx, a);
      check(a, 1, "index ack");
      i_master.send(d, a);
      check(a, 1, "data ack");
      i_master.stop();
   endtask

   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      logic a;
      i_master.start();
      i_master.send(WA, a);
      i_master.send(idx, a);
      i_master.start();
      i_master.send(RA, a);
      check(a, 1, "read address ack");
      i_master.recv(1'b1, d);
      i_master.stop();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check(ctrl, `RGI_CTRL_RST, "ctrl");
      check(buck1, `RGI_BUCK1_RST, "buck1");
      check(buck2, `RGI_BUCK2_RST, "buck2");
      check({busy, sda_oe, scl_oe}, 0, "idle");
   endtask

   task automatic t_write_read();
      logic [7:0] d;
      wr(`RGI_IDX_BUCK1, 8'h2a);
      check(buck1, 8'h2a, "buck1");
      check(pwm_force, 2'b01, "forced pwm");
      check(vcode1, 5'h0a, "code1");
      rd(`RGI_IDX_BUCK1, d);
      check(d, 8'h2a, "read buck1");
      wr(`RGI_IDX_BUCK2, 8'h50);
      check({por_dis, vcode2}, 6'h30, "buck2 fields");
      rd(`RGI_IDX_BUCK2, d);
      check(d, 8'h50, "read buck2");
   endtask

   task automatic t_abort();
      logic a;
      i_master.start();
      check(busy, 1, "busy");
      for (int i = 7; i > 3; i--) i_master.put_bit(WA[i]);
      wr(`RGI_IDX_BUCK1, 8'h08);
      check(buck1, 8'h08, "after abort");
      check(busy, 0, "free");
   endtask

   task automatic t_foreign();
      logic a;
      i_master.start();
      i_master.send(8'h6e, a);
      check(a, 0, "foreign address");
      i_master.send(`RGI_IDX_BUCK1, a);
      check(a, 0, "foreign index");
      i_master.stop();
      wr(8'h03, 8'hff);
      check(ctrl, 8'h00, "ctrl unchanged");
      check(buck1, 8'h08, "buck1 unchanged");
      check(buck2, 8'h50, "buck2 unchanged");
   endtask

   task automatic t_stream();
      logic a;
      hold = 1'b1;
      i_master.start();
      i_master.send(WA, a);
      i_master.send(`RGI_IDX_BUCK1, a);
      i_master.send(8'h05, a);
      i_master.send(8'h03, a);
      check(a, 1, "second data ack");
      check(buck1, 8'h08, "held");
      fork
         begin
            tick(600);
            hold = 1'b0;
         end
      join_none
      i_master.send(8'h07, a);
      check(a, 1, "third data ack");
      i_master.stop();
      check(buck1, 8'h05, "buck1");
      check(buck2, 8'h03, "buck2");
   endtask

   task automatic t_microstep();
      wr(`RGI_IDX_CTRL, 8'h01);
      wr(`RGI_IDX_BUCK1, 8'h08);
      check(vcode1 inside {5'h05, 5'h06}, 1, "ramp start");
      tick(3 * STEP + 100);
      check(vcode1, 5'h08, "ramp end");
   endtask

   task automatic t_soft();
      ss_cnt = '{0, 0};
      en = 2'b01;
      tick(60);
      check(ss_cnt[0], 0, "no launch");
      en = 2'b00;
      vin_ok = 1'b1;
      tick(60);
      en = 2'b11;
      tick(60);
      check(ss_cnt[0], 1, "launch ch1");
      check(ss_cnt[1], 1, "launch ch2");
   endtask

   task automatic t_glitch();
      i_master.glitch(12);
      tick(40);
      check(busy, 0, "spike");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      en = 2'b00;
      vin_ok = 1'b0;
      hold = 1'b0;
      tick(2);
      rst = 1'b0;
      tick(30);
      t_reset();
      t_write_read();
      t_abort();
      t_foreign();
      t_stream();
      t_microstep();
      t_soft();
      t_glitch();
      give_verdict();
   end

   initial begin
      tick(100000);
      fails++;
      give_verdict();
   end
endmodule // regulator_i2c_register_port_bench

// ---- verif/rgi_master.sv ----
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// bus master model: pulls lines low or releases them, 160 ns bus clock
module rgi_master (
   input  wire logic clock_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_low_o,
   output logic      sda_low_o
);
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clock_i);
   endtask

   // release scl, then wait out a stretch by the slave
   task automatic rise();
      scl_low_o = 1'b0;
      for (int t = 0; t < 4000 && scl_i !== 1'b1; t++) tick(1);
   endtask

   task automatic put_bit(input logic b);
      tick(10);
      sda_low_o = ~b;
      tick(10);
      rise();
      tick(20);
      scl_low_o = 1'b1;
   endtask

   task automatic get_bit(output logic b);
      tick(10);
      sda_low_o = 1'b0;
      tick(10);
      rise();
      tick(10);
      b = sda_i;
      tick(10);
      scl_low_o = 1'b1;
   endtask

   task automatic start();
      tick(10);
      sda_low_o = 1'b0;
      tick(10);
      rise();
      tick(20);
      sda_low_o = 1'b1;
      tick(20);
      scl_low_o = 1'b1;
   endtask

   task automatic stop();
      tick(10);
      sda_low_o = 1'b1;
      tick(10);
      rise();
      tick(20);
      sda_low_o = 1'b0;
      tick(40);
   endtask

   task automatic glitch(input int n);
      sda_low_o = 1'b1;
      tick(n);
      sda_low_o = 1'b0;
   endtask

   task automatic send(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(a);
      ack = ~a;
   endtask

   task automatic recv(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(last);
   endtask
endmodule // rgi_master
